// >>> hdl/prox_led_pkg.sv
package prox_led_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] LED_PULSE_SETUP_OFS = 8'h8E;
  localparam logic [7:0] DRIVE_GAIN_SETUP_OFS = 8'h8F;
  localparam logic [7:0] SAT_BOOST_SETUP_OFS = 8'h90;
  localparam logic [7:0] PART_NUMBER_CODE_OFS = 8'h92;
  localparam logic [7:0] PROX_SAT_CLEAR_OFS = 8'hE5;
  localparam logic [7:0] LIGHT_SAT_CLEAR_OFS = 8'hE6;
  localparam logic [7:0] ALL_SAT_CLEAR_OFS = 8'hE7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] LED_PULSE_SETUP_RST = 8'h40;
  localparam logic [7:0] DRIVE_GAIN_SETUP_RST = 8'h00;
  localparam logic [7:0] SAT_BOOST_SETUP_RST = 8'h01;
  // Arbitrary identification value
  localparam logic [7:0] PART_NUMBER_CODE_VAL = 8'h5A;

  // ==========================================================
  // Field positions
  localparam int PULSE_COUNT_LSB = 0;
  localparam int PULSE_WIDTH_LSB = 6;
  localparam int LED_CURRENT_LSB = 6;
  localparam int PROX_GAIN_LSB = 2;
  localparam int LIGHT_GAIN_LSB = 0;
  localparam int PROX_SAT_EN_BIT = 7;
  localparam int CLEAR_SAT_EN_BIT = 6;
  localparam int CURRENT_SCALE_LSB = 4;

  // ==========================================================
  // Boost percentages
  localparam logic [8:0] SCALE_PCT_0 = 9'h064;
  localparam logic [8:0] SCALE_PCT_1 = 9'h096;
  localparam logic [8:0] SCALE_PCT_2 = 9'h0C8;
  localparam logic [8:0] SCALE_PCT_3 = 9'h12C;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WIDTH_4US_NS = 4000;
  localparam int WIDTH_8US_NS = 8000;
  localparam int WIDTH_16US_NS = 16000;
  localparam int WIDTH_32US_NS = 32000;
  localparam int LED_EXTRA_NS = 1360;
  localparam int PULSE_GAP_NS = 2000;
  localparam int WIDTH_4US_CYC = (WIDTH_4US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIDTH_8US_CYC = (WIDTH_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIDTH_16US_CYC = (WIDTH_16US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIDTH_32US_CYC = (WIDTH_32US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LED_EXTRA_CYC = (LED_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_GAP_CYC = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PG_IDLE,
    PG_ON,
    PG_GAP
  } pulse_state_t;

  function automatic logic [11:0] width_cycles(input logic [1:0] sel);
    logic [11:0] w;
    w = 12'(WIDTH_4US_CYC);
    case (sel)
      2'h1: w = 12'(WIDTH_8US_CYC);
      2'h2: w = 12'(WIDTH_16US_CYC);
      2'h3: w = 12'(WIDTH_32US_CYC);
      default: w = 12'(WIDTH_4US_CYC);
    endcase
    return w;
  endfunction : width_cycles

endpackage : prox_led_pkg

// >>> hdl/led_pulse_train.sv
module led_pulse_train
  import prox_led_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [5:0] pulse_count_field,
  input wire logic [1:0] pulse_width_sel,
  // Outputs
  output logic led_on,
  output logic integrate,
  output logic busy,
  output logic done
);

  pulse_state_t state_q, state_d;
  logic [11:0] cyc_q, cyc_d;
  logic [5:0] left_q, left_d;
  logic [11:0] width_q, width_d;
  logic led_on_d, integrate_d, busy_d, done_d;

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    left_d = left_q;
    width_d = width_q;
    done_d = 1'b0;
    case (state_q)
      PG_IDLE: begin
        if (start) begin
          state_d = PG_ON;
          cyc_d = 12'h000;
          left_d = pulse_count_field;
          width_d = width_cycles(pulse_width_sel);
        end
      end
      PG_ON: begin
        // LED stays on past the integration window
        if (cyc_q == width_q + 12'(LED_EXTRA_CYC) - 12'h001) begin // [RULE3]
          cyc_d = 12'h000;
          if (left_q == 6'h00) begin // [RULE1] [RULE14]
            state_d = PG_IDLE;
            done_d = 1'b1;
          end else begin
            state_d = PG_GAP;
            left_d = left_q - 6'h01;
          end
        end else begin
          cyc_d = cyc_q + 12'h001;
        end
      end
      PG_GAP: begin
        if (cyc_q == 12'(PULSE_GAP_CYC) - 12'h001) begin
          cyc_d = 12'h000;
          state_d = PG_ON;
        end else begin
          cyc_d = cyc_q + 12'h001;
        end
      end
      default: state_d = PG_IDLE;
    endcase
    led_on_d = (state_d == PG_ON); // [RULE14]
    integrate_d = (state_d == PG_ON) && (cyc_d < width_d); // [RULE2]
    busy_d = (state_d != PG_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= PG_IDLE;
      cyc_q <= 12'h000;
      left_q <= 6'h00;
      width_q <= 12'h000;
      led_on <= 1'b0;
      integrate <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      left_q <= left_d;
      width_q <= width_d;
      led_on <= led_on_d;
      integrate <= integrate_d;
      busy <= busy_d;
      done <= done_d;
    end
  end

endmodule : led_pulse_train

// >>> hdl/prox_led_pulse_config_regs.sv
// Functional notes
// [RULE1] Emit pulse count field plus one pulses
// [RULE2] Width code selects 4/8/16/32 us
// [RULE3] LED stays on about 1.36 us longer
// [RULE4] Pulse setup resets to 0x40
// [RULE5] Boost field raises LED sink current
// [RULE6] Boost codes give 100/150/200/300 percent
// [RULE7] Bit 7 enables proximity saturation interrupt
// [RULE8] Bit 6 enables clear saturation interrupt
// [RULE9] Special addresses clear pending saturation flags
// [RULE10] Bit 0 high at reset; host writes
// [RULE11] Read-only fixed identification register
// [RULE12] Clear saturation plus enable raises interrupt
// [RULE13] Proximity saturation plus enable raises interrupt
// [RULE14] Counter-driven pulses, each asserts LED sink
module prox_led_pulse_config_regs
  import prox_led_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sensor events
  input wire logic prox_cycle_start,
  input wire logic prox_sat_event,
  input wire logic clear_sat_event,
  // LED drive
  output logic led_sink_pin,
  output logic integrate_gate,
  output logic pulse_train_busy,
  output logic pulse_train_done,
  output logic [1:0] led_current_sel,
  output logic [1:0] current_scale_sel,
  output logic [8:0] current_scale_pct,
  // Gain
  output logic [1:0] prox_gain_sel,
  output logic [1:0] light_gain_sel,
  // Saturation status and interrupt
  output logic prox_sat_status,
  output logic clear_sat_status,
  output logic irq
);

  // ==========================================================
  // Register state
  logic [7:0] pulse_setup_q, pulse_setup_d;
  logic [7:0] drive_gain_q, drive_gain_d;
  logic [7:0] sat_boost_q, sat_boost_d;
  logic [7:0] rdata_d;
  logic prox_sat_d, clear_sat_d, irq_d;
  logic [8:0] scale_pct_d;
  logic clr_prox, clr_clear;

  assign clr_prox = (reg_wr || reg_rd)
    && (reg_addr == PROX_SAT_CLEAR_OFS || reg_addr == ALL_SAT_CLEAR_OFS); // [RULE9]
  assign clr_clear = (reg_wr || reg_rd)
    && (reg_addr == LIGHT_SAT_CLEAR_OFS || reg_addr == ALL_SAT_CLEAR_OFS); // [RULE9]

  always_comb begin
    pulse_setup_d = pulse_setup_q;
    drive_gain_d = drive_gain_q;
    sat_boost_d = sat_boost_q;
    if (reg_wr) begin
      case (reg_addr)
        LED_PULSE_SETUP_OFS: pulse_setup_d = reg_wdata;
        DRIVE_GAIN_SETUP_OFS: drive_gain_d = reg_wdata;
        SAT_BOOST_SETUP_OFS: sat_boost_d = reg_wdata; // [RULE10]
        default: pulse_setup_d = pulse_setup_q; // [RULE11]
      endcase
    end
    rdata_d = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        LED_PULSE_SETUP_OFS: rdata_d = pulse_setup_q;
        DRIVE_GAIN_SETUP_OFS: rdata_d = drive_gain_q;
        SAT_BOOST_SETUP_OFS: rdata_d = sat_boost_q;
        PART_NUMBER_CODE_OFS: rdata_d = PART_NUMBER_CODE_VAL; // [RULE11]
        default: rdata_d = 8'h00;
      endcase
    end
    // Set beats a same-cycle clear
    prox_sat_d = prox_sat_event || (prox_sat_status && !clr_prox); // [RULE9]
    clear_sat_d = clear_sat_event || (clear_sat_status && !clr_clear); // [RULE9]
    irq_d = (clear_sat_d && sat_boost_d[CLEAR_SAT_EN_BIT]) // [RULE8] [RULE12]
      || (prox_sat_d && sat_boost_d[PROX_SAT_EN_BIT]); // [RULE7] [RULE13]
    case (sat_boost_d[CURRENT_SCALE_LSB +: 2]) // [RULE5] [RULE6]
      2'h1: scale_pct_d = SCALE_PCT_1;
      2'h2: scale_pct_d = SCALE_PCT_2;
      2'h3: scale_pct_d = SCALE_PCT_3;
      default: scale_pct_d = SCALE_PCT_0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_setup_q <= LED_PULSE_SETUP_RST; // [RULE4]
      drive_gain_q <= DRIVE_GAIN_SETUP_RST;
      sat_boost_q <= SAT_BOOST_SETUP_RST; // [RULE10]
      reg_rdata <= 8'h00;
      prox_sat_status <= 1'b0;
      clear_sat_status <= 1'b0;
      irq <= 1'b0;
      current_scale_sel <= 2'h0;
      current_scale_pct <= SCALE_PCT_0;
      led_current_sel <= 2'h0;
      prox_gain_sel <= 2'h0;
      light_gain_sel <= 2'h0;
    end else begin
      pulse_setup_q <= pulse_setup_d;
      drive_gain_q <= drive_gain_d;
      sat_boost_q <= sat_boost_d;
      reg_rdata <= rdata_d;
      prox_sat_status <= prox_sat_d;
      clear_sat_status <= clear_sat_d;
      irq <= irq_d;
      current_scale_sel <= sat_boost_d[CURRENT_SCALE_LSB +: 2]; // [RULE5]
      current_scale_pct <= scale_pct_d; // [RULE6]
      led_current_sel <= drive_gain_d[LED_CURRENT_LSB +: 2];
      prox_gain_sel <= drive_gain_d[PROX_GAIN_LSB +: 2];
      light_gain_sel <= drive_gain_d[LIGHT_GAIN_LSB +: 2];
    end
  end

  // ==========================================================
  // Pulse train
  led_pulse_train u_pulse (
    .core_clk(core_clk),
    .rst(rst),
    .start(prox_cycle_start),
    .pulse_count_field(pulse_setup_q[PULSE_COUNT_LSB +: 6]), // [RULE1]
    .pulse_width_sel(pulse_setup_q[PULSE_WIDTH_LSB +: 2]), // [RULE2]
    .led_on(led_sink_pin),
    .integrate(integrate_gate),
    .busy(pulse_train_busy),
    .done(pulse_train_done)
  );

endmodule : prox_led_pulse_config_regs

// >>> tb/host_model.sv
module host_model
  import prox_led_pkg::*;
(
  // Bus
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ==========================================
  // Write, strobe held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= (a == SAT_BOOST_SETUP_OFS) ? {d[7:4], 4'h1} : d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask : wr

  // ==========================================
  // Read, data sampled mid-cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// >>> tb/prox_led_assertions.sv
module prox_led_checker (
  // Watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic prox_cycle_start,
  input wire logic prox_sat_event,
  input wire logic clear_sat_event,
  input wire logic led_sink_pin,
  input wire logic integrate_gate,
  input wire logic pulse_train_busy,
  input wire logic [1:0] current_scale_sel,
  input wire logic [8:0] current_scale_pct,
  input wire logic prox_sat_status,
  input wire logic clear_sat_status,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================
  // Pulse steps
  sequence s_train_up;
    led_sink_pin && integrate_gate && pulse_train_busy;
  endsequence
  sequence s_led_tail;
    (!integrate_gate && led_sink_pin) [*8];
  endsequence

  AST_TRAIN_START: assert property (prox_cycle_start && !pulse_train_busy |=> s_train_up)
    else $error("pulse train did not start");
  AST_LED_TAIL: assert property ($fell(integrate_gate) |-> s_led_tail)
    else $error("led not extended past integration");
  AST_INTEG_LED: assert property (integrate_gate |-> led_sink_pin)
    else $error("integration without led");
  AST_BOOST: assert property (current_scale_pct == (current_scale_sel == 2'h0 ? 9'h064 :
    current_scale_sel == 2'h1 ? 9'h096 : current_scale_sel == 2'h2 ? 9'h0C8 : 9'h12C))
    else $error("boost percentage wrong");
  AST_PROX_SET: assert property (prox_sat_event |=> prox_sat_status)
    else $error("prox saturation not latched");
  AST_CLR_SET: assert property (clear_sat_event |=> clear_sat_status)
    else $error("clear saturation not latched");
  AST_PROX_CLR: assert property ((reg_wr || reg_rd) && reg_addr inside {8'hE5, 8'hE7}
    && !prox_sat_event |=> !prox_sat_status)
    else $error("prox saturation not cleared");
  AST_LIGHT_CLR: assert property ((reg_wr || reg_rd) && reg_addr inside {8'hE6, 8'hE7}
    && !clear_sat_event |=> !clear_sat_status)
    else $error("clear saturation not cleared");
  AST_IRQ_SRC: assert property (irq |-> prox_sat_status || clear_sat_status)
    else $error("irq without saturation");
endmodule : prox_led_checker

bind prox_led_pulse_config_regs prox_led_checker u_prox_led_checker (
  .core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .prox_cycle_start, .prox_sat_event,
  .clear_sat_event, .led_sink_pin, .integrate_gate, .pulse_train_busy,
  .current_scale_sel, .current_scale_pct, .prox_sat_status, .clear_sat_status, .irq
);

// >>> tb/testbench.sv
module testbench
  import prox_led_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, prox_cycle_start, prox_sat_event, clear_sat_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, led_sink_pin, integrate_gate, pulse_train_busy, pulse_train_done;
  logic [1:0] led_current_sel, current_scale_sel, prox_gain_sel, light_gain_sel;
  logic [8:0] current_scale_pct;
  logic prox_sat_status, clear_sat_status, irq;
  logic [8:0] pct [4] = '{9'h064, 9'h096, 9'h0C8, 9'h12C};
  int errors = 0;
  int cmp_count = 0;

  prox_led_pulse_config_regs u_prox_led_pulse_config_regs (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prox_cycle_start, .prox_sat_event,
    .clear_sat_event, .led_sink_pin, .integrate_gate, .pulse_train_busy, .pulse_train_done,
    .led_current_sel, .current_scale_sel, .current_scale_pct, .prox_gain_sel,
    .light_gain_sel, .prox_sat_status, .clear_sat_status, .irq);
  host_model u_host_model (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // ==========================================
  // One-cycle saturation events
  task automatic ev(input logic p, input logic c);
    @(posedge core_clk);
    prox_sat_event <= p;
    clear_sat_event <= c;
    @(posedge core_clk);
    prox_sat_event <= 1'b0;
    clear_sat_event <= 1'b0;
    @(negedge core_clk);
  endtask : ev

  // ==========================================
  // Run one train and count led activity
  task automatic train(input logic [7:0] cfg, input int np, input int w);
    int led;
    int integ;
    int rises;
    logic last;
    led = 0;
    integ = 0;
    rises = 0;
    last = 1'b0;
    u_host_model.wr(LED_PULSE_SETUP_OFS, cfg);
    @(posedge core_clk);
    prox_cycle_start <= 1'b1;
    @(posedge core_clk);
    prox_cycle_start <= 1'b0;
    for (int c = 0; c < 40000; c++) begin
      @(negedge core_clk);
      led += (led_sink_pin === 1'b1);
      integ += (integrate_gate === 1'b1);
      rises += (led_sink_pin === 1'b1 && last !== 1'b1);
      last = led_sink_pin;
      if (pulse_train_done === 1'b1) break;
    end
    chk("pulses", np, rises);
    chk("integrate", np * w, integ);
    chk("led_on", np * (w + 55), led);
    chk("done", 32'h1, pulse_train_done);
  endtask : train

  initial begin
    rst = 1'b1;
    prox_cycle_start = 1'b0;
    prox_sat_event = 1'b0;
    clear_sat_event = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    u_host_model.rd(LED_PULSE_SETUP_OFS, rv);
    chk("pulse_setup", 8'h40, rv);
    u_host_model.rd(SAT_BOOST_SETUP_OFS, rv);
    chk("boost_setup", 8'h01, rv);
    u_host_model.rd(DRIVE_GAIN_SETUP_OFS, rv);
    chk("drive_gain_setup", 8'h00, rv);
    u_host_model.wr(DRIVE_GAIN_SETUP_OFS, 8'hC9);
    chk("led_current_sel", 32'h3, led_current_sel);
    chk("prox_gain_sel", 32'h2, prox_gain_sel);
    chk("light_gain_sel", 32'h1, light_gain_sel);
    u_host_model.rd(DRIVE_GAIN_SETUP_OFS, rv);
    chk("drive_gain_back", 8'hC9, rv);
    u_host_model.wr(PART_NUMBER_CODE_OFS, 8'hFF);
    u_host_model.rd(PART_NUMBER_CODE_OFS, rv);
    chk("part_code", PART_NUMBER_CODE_VAL, rv);
    u_host_model.rd(8'h91, rv);
    chk("unmapped", 8'h00, rv);
    for (int i = 0; i < 4; i++) begin
      u_host_model.wr(SAT_BOOST_SETUP_OFS, {2'h0, 2'(i), 4'h1});
      chk("scale_pct", pct[i], current_scale_pct);
      chk("scale_sel", 32'(i), current_scale_sel);
    end
    u_host_model.wr(SAT_BOOST_SETUP_OFS, 8'h81);
    ev(1'b1, 1'b1);
    chk("irq_prox", 32'h1, irq);
    u_host_model.wr(PROX_SAT_CLEAR_OFS, 8'h00);
    chk("prox_sat", 32'h0, prox_sat_status);
    chk("irq_masked", 32'h0, irq);
    u_host_model.wr(SAT_BOOST_SETUP_OFS, 8'h41);
    chk("irq_clear", 32'h1, irq);
    u_host_model.rd(LIGHT_SAT_CLEAR_OFS, rv);
    chk("clear_sat", 32'h0, clear_sat_status);
    ev(1'b1, 1'b0);
    chk("irq_off", 32'h0, irq);
    ev(1'b0, 1'b1);
    u_host_model.wr(ALL_SAT_CLEAR_OFS, 8'h00);
    chk("both_sat", 32'h0, {prox_sat_status, clear_sat_status});
    train(8'h02, 3, 160);
    train(8'hC0, 1, 1280);
    train(8'h80, 1, 640);
    train(8'h7F, 64, 320);
    // Mid-run reset restores the documented values
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    u_host_model.rd(LED_PULSE_SETUP_OFS, rv);
    chk("pulse_setup_rerst", 8'h40, rv);
    u_host_model.rd(SAT_BOOST_SETUP_OFS, rv);
    chk("boost_setup_rerst", 8'h01, rv);
    u_host_model.rd(DRIVE_GAIN_SETUP_OFS, rv);
    chk("drive_gain_rerst", 8'h00, rv);
    chk("led_current_rerst", 32'h0, led_current_sel);
    close_out();
  end

  initial begin
    repeat (50000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule : testbench
